/* rtl/bdc_pkg.sv */
package bdc_pkg;

   localparam logic [7:0] BDC_OFS_ZERO = 8'hc0;
   localparam logic [7:0] BDC_OFS_ONE  = 8'hc4;

   localparam logic [31:0] BDC_RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] BDC_RST_ONE  = 32'h0012_0108;

   // bits that software may change; everything else reads as zero
   localparam logic [31:0] BDC_RW_ZERO = 32'h0000_003e;
   localparam logic [31:0] BDC_RW_ONE  = 32'h001f_ffff;

   localparam logic [1:0] BDC_THR_PLUS4  = 2'h0;
   localparam logic [1:0] BDC_THR_PLUS8  = 2'h1;
   localparam logic [1:0] BDC_THR_PLUS12 = 2'h2;
   localparam logic [1:0] BDC_THR_TWO4   = 2'h3;
   localparam logic [9:0] BDC_DW_4       = 10'h004;
   localparam logic [9:0] BDC_DW_8       = 10'h008;
   localparam logic [9:0] BDC_DW_12      = 10'h00c;
   localparam logic [7:0] BDC_CL_DEFAULT = 8'h08;

   localparam logic [2:0] BDC_LAT_RESET = 3'h4;

   localparam int BDC_CLK_NS        = 100;
   localparam int BDC_DEEP_TICK_NS  = 512;
   localparam int BDC_SHAL_TICK_PS  = 16000;
   localparam int BDC_DEEP_TICK_CYC =
      (BDC_DEEP_TICK_NS + BDC_CLK_NS - 1) / BDC_CLK_NS;
   localparam int BDC_SHAL_RAW =
      (BDC_SHAL_TICK_PS + BDC_CLK_NS * 1000 - 1) / (BDC_CLK_NS * 1000);
   localparam int BDC_SHAL_TICK_CYC = (BDC_SHAL_RAW < 1) ? 1 : BDC_SHAL_RAW;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } bdc_cfg_req_s;

   typedef struct packed {
      logic [25:0] upper;
      logic [1:0]  buf_threshold;
      logic        threshold_mode_en;
      logic        cfg_mem_regs_en;
      logic        rsvd_rw;
      logic        rsvd_ro;
   } bdc_zero_s;

   typedef struct packed {
      logic [10:0] rsvd_ro;
      logic [2:0]  exit_latency_separate_refclk;
      logic [2:0]  exit_latency_shared_refclk;
      logic [3:0]  rsvd_rw_hi;
      logic        secondary_reset_block;
      logic [3:0]  deep_idle_entry_timer;
      logic [3:0]  shallow_idle_entry_timer;
      logic [1:0]  rsvd_rw_lo;
   } bdc_one_s;

endpackage

/* rtl/bdc_idle_timer.sv */
module bdc_idle_timer
   import bdc_pkg::*;
#(
   parameter int TICK_CYC = 1
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_idle,
   input  wire logic [3:0] i_limit,
   output logic            o_expired
);
   localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

   logic [7:0] pre_q;
   logic [3:0] ticks_q;

   // prescaler turns clock cycles into timer ticks while idle
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !i_idle || pre_q == TICK_LAST) begin
         pre_q <= 8'h00;
      end else begin
         pre_q <= pre_q + 8'h01;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !i_idle) begin
         ticks_q <= 4'h0;
      end else if (pre_q == TICK_LAST && ticks_q != i_limit) begin
         ticks_q <= ticks_q + 4'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_expired <= 1'b0;
      end else begin
         o_expired <= i_idle && (ticks_q == i_limit);
      end
   end
endmodule

/* rtl/bdc_regs.sv */
// Overview of operation
// - threshold field picks one or two cache lines plus DW
// - invalid cache line size counts as 8 DW
// - with threshold mode on, accept upstream only with threshold space free
// - threshold mode enable resets cleared
// - bit 2 opens config access to mapped regs
// - first register bit 0 reads zero
// - second register bits 31:21 read zero
// - shared refclk flag set mirrors separate latency
// - flag clear mirrors shared refclk latency
// - block bit suppresses secondary bus reset
// - deep idle timer 512 ns ticks, reset 0100b; code ticks every 6 clocks (600 ns)
// - shallow idle timer 62.5 MHz ticks, reset 0010b; code ticks every 100 ns clock
// - fields reset only by fundamental reset
module bdc_regs
   import bdc_pkg::*;
(
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_fundamental_reset_event,
   input  wire bdc_cfg_req_s i_cfg,
   output logic              o_cfg_ack,
   output logic [31:0]       o_cfg_rdata,
   input  wire logic         i_common_refclk_config_flag,
   output logic [2:0]        o_link_caps_exit_latency,
   input  wire logic         i_secondary_bus_reset_request,
   output logic              o_secondary_bus_reset,
   input  wire logic [7:0]   i_cache_line_size,
   input  wire logic [11:0]  i_buf_free_dw,
   input  wire logic         i_upstream_req,
   output logic              o_upstream_accept,
   output logic              o_cfg_mem_regs_enable,
   input  wire logic         i_link_idle,
   output logic              o_deep_idle_entry,
   output logic              o_shallow_idle_entry
);
   bdc_zero_s   zero_q;
   bdc_one_s    one_q;
   logic        full_rst;
   logic [31:0] be_mask;
   logic [7:0]  cl_eff;
   logic        cl_valid;
   logic [9:0]  thr_dw;

   assign full_rst = !i_rst_n && i_fundamental_reset_event;
   assign be_mask  = {{8{i_cfg.be[3]}}, {8{i_cfg.be[2]}}, {8{i_cfg.be[1]}}, {8{i_cfg.be[0]}}};

   always_ff @(posedge i_clk) begin
      if (full_rst) begin
         zero_q <= bdc_zero_s'(BDC_RST_ZERO);
      end else if (i_rst_n && i_cfg.wr && i_cfg.addr == BDC_OFS_ZERO) begin
         zero_q <= bdc_zero_s'((zero_q & ~(be_mask & BDC_RW_ZERO))
                               | (i_cfg.wdata & be_mask & BDC_RW_ZERO));
      end
   end

   always_ff @(posedge i_clk) begin
      if (full_rst) begin
         one_q <= bdc_one_s'(BDC_RST_ONE);
      end else if (i_rst_n && i_cfg.wr && i_cfg.addr == BDC_OFS_ONE) begin
         one_q <= bdc_one_s'((one_q & ~(be_mask & BDC_RW_ONE))
                             | (i_cfg.wdata & be_mask & BDC_RW_ONE));
      end
   end

   // read data and acknowledge one cycle after the request
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_cfg_ack   <= 1'b0;
         o_cfg_rdata <= 32'h0000_0000;
      end else begin
         o_cfg_ack <= i_cfg.rd || i_cfg.wr;
         if (i_cfg.rd && i_cfg.addr == BDC_OFS_ZERO) begin
            o_cfg_rdata <= 32'(zero_q);
         end else if (i_cfg.rd && i_cfg.addr == BDC_OFS_ONE) begin
            o_cfg_rdata <= 32'(one_q);
         end else begin
            o_cfg_rdata <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_link_caps_exit_latency <= BDC_LAT_RESET;
      end else if (i_common_refclk_config_flag) begin
         o_link_caps_exit_latency <= one_q.exit_latency_separate_refclk;
      end else begin
         o_link_caps_exit_latency <= one_q.exit_latency_shared_refclk;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_secondary_bus_reset <= 1'b0;
      end else begin
         o_secondary_bus_reset <= i_secondary_bus_reset_request
                                  && !one_q.secondary_reset_block;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_cfg_mem_regs_enable <= 1'b0;
      end else begin
         o_cfg_mem_regs_enable <= zero_q.cfg_mem_regs_en;
      end
   end

   assign cl_valid = (i_cache_line_size != 8'h00)
                     && ((i_cache_line_size & (i_cache_line_size - 8'h01)) == 8'h00);
   assign cl_eff   = cl_valid ? i_cache_line_size : BDC_CL_DEFAULT;

   always_comb begin
      case (zero_q.buf_threshold)
         BDC_THR_PLUS4:  thr_dw = {2'h0, cl_eff} + BDC_DW_4;
         BDC_THR_PLUS8:  thr_dw = {2'h0, cl_eff} + BDC_DW_8;
         BDC_THR_PLUS12: thr_dw = {2'h0, cl_eff} + BDC_DW_12;
         default:        thr_dw = {1'b0, cl_eff, 1'b0} + BDC_DW_4;
      endcase
   end

   assign o_upstream_accept = i_upstream_req
                              && (!zero_q.threshold_mode_en || i_buf_free_dw >= {2'h0, thr_dw});

   bdc_idle_timer #(
      .TICK_CYC (BDC_DEEP_TICK_CYC)
   ) u_deep (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_idle    (i_link_idle),
      .i_limit   (one_q.deep_idle_entry_timer),
      .o_expired (o_deep_idle_entry)
   );

   bdc_idle_timer #(
      .TICK_CYC (BDC_SHAL_TICK_CYC)
   ) u_shallow (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_idle    (i_link_idle),
      .i_limit   (one_q.shallow_idle_entry_timer),
      .o_expired (o_shallow_idle_entry)
   );

   chk_ro_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_cfg_ack |-> (o_cfg_rdata[31:21] == 11'h000 && o_cfg_rdata[0] == 1'b0))
      else $error("read-only bits returned nonzero");

   chk_lat_separate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_common_refclk_config_flag ##1 i_rst_n
      |-> o_link_caps_exit_latency == $past(one_q.exit_latency_separate_refclk))
      else $error("separate refclk latency not mirrored");

   chk_lat_shared: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !i_common_refclk_config_flag ##1 i_rst_n
      |-> o_link_caps_exit_latency == $past(one_q.exit_latency_shared_refclk))
      else $error("shared refclk latency not mirrored");

   chk_secondary_bus_reset_request_block: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_secondary_bus_reset_request && one_q.secondary_reset_block) |=> !o_secondary_bus_reset)
      else $error("masked secondary reset leaked");

   chk_accept_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (zero_q.threshold_mode_en && i_buf_free_dw < {2'h0, thr_dw}) |-> !o_upstream_accept)
      else $error("accepted without threshold space");

   chk_thr_two: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      zero_q.buf_threshold == BDC_THR_TWO4
      |-> thr_dw == {2'h0, cl_eff} + {2'h0, cl_eff} + BDC_DW_4)
      else $error("two line threshold wrong");

   chk_cl_default: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_cache_line_size == 8'h00 |-> thr_dw >= BDC_DW_8 + BDC_DW_4)
      else $error("invalid line size not replaced");

   chk_fundamental_reset_event_vals: assert property (@(posedge i_clk)
      full_rst |=> (32'(one_q) == BDC_RST_ONE && !zero_q.threshold_mode_en))
      else $error("fundamental reset values wrong");

   chk_warm_keep: assert property (@(posedge i_clk)
      (!i_rst_n && !i_fundamental_reset_event) |=> ($stable(one_q) && $stable(zero_q)))
      else $error("warm reset disturbed fields");

   chk_cfg_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_rst_n |=> o_cfg_mem_regs_enable == $past(zero_q.cfg_mem_regs_en))
      else $error("config access gate not following bit 2");

   chk_secondary_bus_reset_request_pass: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_secondary_bus_reset_request && !one_q.secondary_reset_block) |=> o_secondary_bus_reset)
      else $error("unmasked secondary reset dropped");

   chk_mode_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !zero_q.threshold_mode_en |-> o_upstream_accept == i_upstream_req)
      else $error("upstream gated with threshold mode off");

   chk_idle_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !i_link_idle |=> (!o_deep_idle_entry && !o_shallow_idle_entry))
      else $error("idle entry held after link busy");
endmodule

/* tb/bdc_regs_bench.sv */
module bdc_regs_bench
   import bdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic         i_clk;
   logic         i_rst_n;
   logic         i_fundamental_reset_event;
   bdc_cfg_req_s i_cfg;
   logic         o_cfg_ack;
   logic [31:0]  o_cfg_rdata;
   logic         i_common_refclk_config_flag;
   logic [2:0]   o_link_caps_exit_latency;
   logic         i_secondary_bus_reset_request;
   logic         o_secondary_bus_reset;
   logic [7:0]   i_cache_line_size;
   logic [11:0]  i_buf_free_dw;
   logic         i_upstream_req;
   logic         o_upstream_accept;
   logic         o_cfg_mem_regs_enable;
   logic         i_link_idle;
   logic         o_deep_idle_entry;
   logic         o_shallow_idle_entry;
   int           mismatches;
   int           check_count;
   int           cycles;
   int           thr;

   bdc_regs bdc_regs_i (
      .i_clk                         (i_clk),
      .i_rst_n                       (i_rst_n),
      .i_fundamental_reset_event     (i_fundamental_reset_event),
      .i_cfg                         (i_cfg),
      .o_cfg_ack                     (o_cfg_ack),
      .o_cfg_rdata                   (o_cfg_rdata),
      .i_common_refclk_config_flag   (i_common_refclk_config_flag),
      .o_link_caps_exit_latency      (o_link_caps_exit_latency),
      .i_secondary_bus_reset_request (i_secondary_bus_reset_request),
      .o_secondary_bus_reset         (o_secondary_bus_reset),
      .i_cache_line_size             (i_cache_line_size),
      .i_buf_free_dw                 (i_buf_free_dw),
      .i_upstream_req                (i_upstream_req),
      .o_upstream_accept             (o_upstream_accept),
      .o_cfg_mem_regs_enable         (o_cfg_mem_regs_enable),
      .i_link_idle                   (i_link_idle),
      .o_deep_idle_entry             (o_deep_idle_entry),
      .o_shallow_idle_entry          (o_shallow_idle_entry)
   );

   always #50 i_clk = ~i_clk;

   task automatic close_out();
      if (mismatches == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         close_out();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_cfg <= '{rd: ~w, wr: w, addr: a, be: 4'hf, wdata: d};
      @(posedge i_clk);
      i_cfg <= '0;
      #1;
      check("ack", {31'h0, o_cfg_ack}, 32'h1);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      access(1'b0, a, 32'h0);
      check("rdata", o_cfg_rdata, exp);
   endtask

   task automatic do_reset(input logic fund);
      @(posedge i_clk);
      i_rst_n                   <= 1'b0;
      i_fundamental_reset_event <= fund;
      repeat (16) @(posedge i_clk);
      i_rst_n                   <= 1'b1;
      i_fundamental_reset_event <= 1'b0;
   endtask

   task automatic acc_chk(input logic [11:0] free, input logic exp);
      @(posedge i_clk);
      i_buf_free_dw <= free;
      #1;
      check("accept", {31'h0, o_upstream_accept}, {31'h0, exp});
   endtask

   initial begin
      i_clk = 1'b0;
      i_rst_n = 1'b0;
      i_fundamental_reset_event = 1'b1;
      i_cfg = '0;
      i_common_refclk_config_flag = 1'b0;
      i_secondary_bus_reset_request = 1'b0;
      i_cache_line_size = 8'h10;
      i_buf_free_dw = 12'h000;
      i_upstream_req = 1'b0;
      i_link_idle = 1'b0;
      do_reset(1'b1);
      rd_chk(BDC_OFS_ONE, 32'h0012_0108);
      rd_chk(BDC_OFS_ZERO, 32'h0000_0000);
      rd_chk(8'h80, 32'h0000_0000);
      @(posedge i_clk);
      i_link_idle <= 1'b1;
      step(1);
      check("shallow early", {31'h0, o_shallow_idle_entry}, 32'h0);
      step(11);
      check("shallow late", {31'h0, o_shallow_idle_entry}, 32'h1);
      check("deep early", {31'h0, o_deep_idle_entry}, 32'h0);
      step(28);
      check("deep late", {31'h0, o_deep_idle_entry}, 32'h1);
      @(posedge i_clk);
      i_link_idle <= 1'b0;
      step(3);
      check("idle drop", {30'h0, o_deep_idle_entry, o_shallow_idle_entry}, 32'h0);
      access(1'b1, BDC_OFS_ONE, 32'hffff_87fc);
      rd_chk(BDC_OFS_ONE, 32'h001f_87fc);
      access(1'b1, BDC_OFS_ZERO, 32'hffff_fffd);
      rd_chk(BDC_OFS_ZERO, 32'h0000_003c);
      access(1'b1, BDC_OFS_ONE, 32'h0015_0000);
      step(2);
      check("lat shared", {29'h0, o_link_caps_exit_latency}, 32'h2);
      @(posedge i_clk);
      i_common_refclk_config_flag <= 1'b1;
      step(2);
      check("lat separate", {29'h0, o_link_caps_exit_latency}, 32'h5);
      @(posedge i_clk);
      i_secondary_bus_reset_request <= 1'b1;
      access(1'b1, BDC_OFS_ONE, 32'h0000_0400);
      step(2);
      check("sec reset masked", {31'h0, o_secondary_bus_reset}, 32'h0);
      access(1'b1, BDC_OFS_ONE, 32'h0000_0000);
      step(2);
      check("sec reset open", {31'h0, o_secondary_bus_reset}, 32'h1);
      access(1'b1, BDC_OFS_ZERO, 32'h0000_0004);
      step(1);
      check("cfg mem", {31'h0, o_cfg_mem_regs_enable}, 32'h1);
      @(posedge i_clk);
      i_upstream_req <= 1'b1;
      acc_chk(12'h000, 1'b1);
      for (int k = 0; k < 4; k++) begin
         thr = (k == 3) ? 36 : 20 + 4 * k;
         access(1'b1, BDC_OFS_ZERO, 32'(k * 16 + 8));
         acc_chk(12'(thr - 1), 1'b0);
         acc_chk(12'(thr), 1'b1);
      end
      check("cfg mem off", {31'h0, o_cfg_mem_regs_enable}, 32'h0);
      @(posedge i_clk);
      i_cache_line_size <= 8'h00;
      acc_chk(12'd19, 1'b0);
      acc_chk(12'd20, 1'b1);
      @(posedge i_clk);
      i_cache_line_size <= 8'h03;
      acc_chk(12'd19, 1'b0);
      acc_chk(12'd20, 1'b1);
      @(posedge i_clk);
      i_upstream_req <= 1'b0;
      acc_chk(12'd40, 1'b0);
      access(1'b1, BDC_OFS_ONE, 32'h0000_0440);
      do_reset(1'b0);
      rd_chk(BDC_OFS_ONE, 32'h0000_0440);
      do_reset(1'b1);
      rd_chk(BDC_OFS_ONE, 32'h0012_0108);
      rd_chk(BDC_OFS_ZERO, 32'h0000_0000);
      close_out();
   end
endmodule
